/* src/limit_alert_pkg.sv */
`default_nettype none
package limit_alert_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_POWER = 8'h03;
  localparam logic [7:0] ADDR_CURRENT = 8'h04;
  localparam logic [7:0] ADDR_SHUNT_LIM = 8'h06;
  localparam logic [7:0] ADDR_BUS_LIM = 8'h07;
  localparam logic [7:0] ADDR_WARN = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h09;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int UPPER_MSB = 15;
  localparam int UPPER_LSB = 8;
  localparam int LOWER_MSB = 7;
  localparam int LOWER_LSB = 0;
  localparam int BIT_SHUNT_OVER = 3;
  localparam int BIT_SHUNT_UNDER = 2;
  localparam int BIT_BUS_OVER = 1;
  localparam int BIT_BUS_UNDER = 0;
  localparam int BIT_FORCE = 8;
  localparam int BIT_ALERT_EN = 7;
  localparam int BIT_EXT_TB = 6;
  localparam int DIV_MSB = 5;
  localparam int DIV_W = 6;
  // ****************************************
  // Reset values and scaling
  // ****************************************
  localparam logic [15:0] RST_SHUNT_LIM = 16'h7f80;
  localparam logic [15:0] RST_BUS_LIM = 16'hff00;
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] CTRL_MASK = 16'h01ff;
  // Shunt reading is 10 uV per count, limit 2560 uV per count
  localparam int SHUNT_LSB_UV = 10;
  localparam int SHUNT_LIM_LSB_UV = 2560;
  localparam int SHUNT_SCALE = SHUNT_LIM_LSB_UV / SHUNT_LSB_UV;
  // Bus reading is 4 mV per count, limit 256 mV per count
  localparam int BUS_LSB_MV = 4;
  localparam int BUS_LIM_LSB_MV = 256;
  localparam int BUS_SCALE = BUS_LIM_LSB_MV / BUS_LSB_MV;
  localparam int CLK_HZ = 10000000;
endpackage
`default_nettype wire

/* src/limit_alert_and_timebase_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module limit_alert_and_timebase_ctrl #(
  parameter int DIV_WIDTH = limit_alert_pkg::DIV_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Conversion results
  input wire logic conv_done,
  input wire logic signed [15:0] shunt_reading,
  input wire logic [15:0] bus_reading,
  input wire logic signed [15:0] current_value,
  input wire logic [15:0] power_value,
  // Timebase or alert pin
  input wire logic timebase_or_alert_pin_i,
  output logic timebase_or_alert_pin_o,
  output logic timebase_or_alert_pin_oe,
  // Timebase control
  output logic osc_enable,
  output logic internal_tick
);
  import limit_alert_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] shunt_lim_q;
  logic [15:0] bus_lim_q;
  logic [15:0] ctrl_q;
  logic [3:0] flags_q;
  logic [15:0] current_q;
  logic [15:0] power_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shunt_lim_q <= RST_SHUNT_LIM;
      bus_lim_q <= RST_BUS_LIM;
      ctrl_q <= RST_CTRL;
    end else if (reg_wr) begin
      if (hit(reg_addr, ADDR_SHUNT_LIM)) begin
        shunt_lim_q <= reg_wdata;
      end
      if (hit(reg_addr, ADDR_BUS_LIM)) begin
        bus_lim_q <= reg_wdata;
      end
      if (hit(reg_addr, ADDR_CTRL)) begin
        ctrl_q <= reg_wdata & CTRL_MASK;
      end
    end
  end

  // Results captured at each conversion so a read sees a coherent pair
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      current_q <= 16'h0000;
      power_q <= 16'h0000;
    end else if (conv_done) begin
      current_q <= current_value;
      power_q <= power_value;
    end
  end

  // ****************************************
  // Limit compare
  // ****************************************
  logic signed [7:0] s_up;
  logic signed [7:0] s_lo;
  logic signed [17:0] s_up_scaled;
  logic signed [17:0] s_lo_scaled;
  logic signed [17:0] s_read;
  logic [15:0] b_up_scaled;
  logic [15:0] b_lo_scaled;
  logic [15:0] b_read;
  logic [3:0] trip;

  always_comb begin
    s_up = shunt_lim_q[UPPER_MSB:UPPER_LSB];
    s_lo = shunt_lim_q[LOWER_MSB:LOWER_LSB];
    // Limits scaled to reading units; 18 bits keep -128*256 exact
    s_up_scaled = 18'(s_up) * 18'(SHUNT_SCALE);
    s_lo_scaled = 18'(s_lo) * 18'(SHUNT_SCALE);
    s_read = 18'(shunt_reading);
    // Bus reading carries status in bits 1:0, value above them
    b_read = {2'b00, bus_reading[15:2]};
    b_up_scaled = 16'(bus_lim_q[UPPER_MSB:UPPER_LSB]) * 16'(BUS_SCALE);
    b_lo_scaled = 16'(bus_lim_q[LOWER_MSB:LOWER_LSB]) * 16'(BUS_SCALE);
    trip = 4'h0;
    trip[BIT_SHUNT_OVER] = s_read > s_up_scaled;
    trip[BIT_SHUNT_UNDER] = s_read < s_lo_scaled;
    trip[BIT_BUS_OVER] = b_read > b_up_scaled;
    trip[BIT_BUS_UNDER] = b_read < b_lo_scaled;
  end

  // ****************************************
  // Warning flags
  // ****************************************
  logic [3:0] clr;
  assign clr = (reg_wr && hit(reg_addr, ADDR_WARN)) ? reg_wdata[3:0] : 4'h0;

  // A trip in the clearing cycle wins, so no event is lost
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flags_q <= 4'h0;
    end else begin
      flags_q <= (flags_q & ~clr) | (conv_done ? trip : 4'h0);
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      // Data follows the address every cycle; valid marks a requested word
      reg_rvalid <= reg_rd;
      case (reg_addr)
        ADDR_POWER: reg_rdata <= power_q;
        ADDR_CURRENT: reg_rdata <= current_q;
        ADDR_SHUNT_LIM: reg_rdata <= shunt_lim_q;
        ADDR_BUS_LIM: reg_rdata <= bus_lim_q;
        ADDR_WARN: reg_rdata <= {12'h000, flags_q};
        ADDR_CTRL: reg_rdata <= ctrl_q;
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  // ****************************************
  // Alert pin
  // ****************************************
  logic ext_tb;
  logic alert_low;
  assign ext_tb = ctrl_q[BIT_EXT_TB];
  // Open-drain style: drive low only, float high
  assign alert_low = ctrl_q[BIT_FORCE]
    | (ctrl_q[BIT_ALERT_EN] & (|flags_q));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timebase_or_alert_pin_o <= 1'b0;
      timebase_or_alert_pin_oe <= 1'b0;
      osc_enable <= 1'b1;
    end else begin
      timebase_or_alert_pin_o <= 1'b0;
      // Clock input mode releases the pin whatever the alert state
      timebase_or_alert_pin_oe <= alert_low & ~ext_tb;
      osc_enable <= ~ext_tb;
    end
  end

  // ****************************************
  // External timebase divider
  // ****************************************
  // Pin must hold each level for two clk_sys cycles to be seen, so its rate is at most a quarter of clk_sys
  logic [2:0] pin_sync_q;
  logic pin_level_q;
  logic pin_rise;
  logic [DIV_WIDTH-1:0] div_cnt_q;

  always_ff @(posedge clk_sys) begin
    // The pin idles high on its pull-up; starting there avoids a false rise
    if (rst) begin
      pin_sync_q <= 3'b111;
      pin_level_q <= 1'b1;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], timebase_or_alert_pin_i};
      if (pin_sync_q[2] == pin_sync_q[1]) begin
        pin_level_q <= pin_sync_q[2];
      end
    end
  end

  assign pin_rise = (pin_sync_q[2] == pin_sync_q[1]) & pin_sync_q[2]
    & ~pin_level_q;

  // Toggling every (div+1) rises gives pin rate over 2*(div+1)
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_cnt_q <= '0;
      internal_tick <= 1'b0;
    end else if (!ext_tb) begin
      div_cnt_q <= '0;
      internal_tick <= 1'b0;
    end else if (pin_rise) begin
      // A divider lowered mid-count wraps at the next edge, no long stall
      if (div_cnt_q >= ctrl_q[DIV_MSB:0]) begin
        div_cnt_q <= '0;
        internal_tick <= ~internal_tick;
      end else begin
        div_cnt_q <= DIV_WIDTH'(div_cnt_q + 1'b1);
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_force_drives: assert property (@(posedge clk_sys) disable iff (rst)
    ctrl_q[BIT_FORCE] && !ext_tb |=> timebase_or_alert_pin_oe)
    else $error("force bit did not drive the pin");
  a_alert_flags: assert property (@(posedge clk_sys) disable iff (rst)
    ctrl_q[BIT_ALERT_EN] && |flags_q && !ext_tb
    |=> timebase_or_alert_pin_oe)
    else $error("enabled flag did not drive the pin");
  a_no_alert: assert property (@(posedge clk_sys) disable iff (rst)
    !ctrl_q[BIT_FORCE] && !ctrl_q[BIT_ALERT_EN]
    |=> !timebase_or_alert_pin_oe)
    else $error("pin driven with alert disabled");
  a_pin_release: assert property (@(posedge clk_sys) disable iff (rst)
    !alert_low |=> !timebase_or_alert_pin_oe)
    else $error("pin not released");
  a_ext_tb: assert property (@(posedge clk_sys) disable iff (rst)
    ext_tb |=> !osc_enable && !timebase_or_alert_pin_oe)
    else $error("timebase mode still drives");
  a_bus_over: assert property (@(posedge clk_sys) disable iff (rst)
    conv_done && b_read > b_up_scaled |=> flags_q[BIT_BUS_OVER])
    else $error("bus over missed");
  a_bus_under: assert property (@(posedge clk_sys) disable iff (rst)
    conv_done && b_read < b_lo_scaled |=> flags_q[BIT_BUS_UNDER])
    else $error("bus under missed");
  a_shunt_over: assert property (@(posedge clk_sys) disable iff (rst)
    conv_done && s_read > s_up_scaled |=> flags_q[BIT_SHUNT_OVER])
    else $error("shunt over missed");
  a_shunt_under: assert property (@(posedge clk_sys) disable iff (rst)
    conv_done && s_read < s_lo_scaled |=> flags_q[BIT_SHUNT_UNDER])
    else $error("shunt under missed");
  a_flag_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !conv_done && clr == 4'h0 |=> flags_q == $past(flags_q))
    else $error("flag changed without cause");
  a_w1c_clear: assert property (@(posedge clk_sys) disable iff (rst)
    !conv_done && clr[0] |=> !flags_q[0])
    else $error("write one did not clear");
  a_drive_low: assert property (@(posedge clk_sys) disable iff (rst)
    !timebase_or_alert_pin_o)
    else $error("pin output level not low");
  a_tick_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !ext_tb |=> !internal_tick && osc_enable)
    else $error("divider ran with timebase off");
  a_tick_still: assert property (@(posedge clk_sys) disable iff (rst)
    ext_tb && !pin_rise |=> internal_tick == $past(internal_tick))
    else $error("divided clock moved without a pin edge");

  // ****************************************
  // Per-flag checks
  // ****************************************
  // One loop keeps the four flags under identical checks
  for (genvar f = 0; f < 4; f++) begin : g_flag_chk
    a_zero_keeps: assert property (@(posedge clk_sys) disable iff (rst)
      flags_q[f] && !clr[f] |=> flags_q[f])
      else $error("flag lost without a clear");
    a_clear_each: assert property (@(posedge clk_sys) disable iff (rst)
      !conv_done && clr[f] |=> !flags_q[f])
      else $error("write one left a flag set");
    a_set_wins: assert property (@(posedge clk_sys) disable iff (rst)
      conv_done && trip[f] && clr[f] |=> flags_q[f])
      else $error("clear beat a new trip");
  end

  c_alert: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(timebase_or_alert_pin_oe));
  c_clear: cover property (@(posedge clk_sys) disable iff (rst)
    flags_q[0] ##1 !flags_q[0]);
  c_tick: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(internal_tick));
  c_set_clash: cover property (@(posedge clk_sys) disable iff (rst)
    conv_done && |(trip & clr));
  c_force: cover property (@(posedge clk_sys) disable iff (rst)
    ctrl_q[BIT_FORCE] && !ext_tb ##1 timebase_or_alert_pin_oe);
endmodule // limit_alert_and_timebase_ctrl
`default_nettype wire

/* bench/reg_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host side of the register port
// ****************************************
module reg_host_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end
  // Warning clears are passed as masks of ones
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    // Released data shows its inverse so a stale value cannot pass
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d,
                    output logic v);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule // reg_host_model
`default_nettype wire

/* bench/limit_alert_and_timebase_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module limit_alert_and_timebase_ctrl_tb;
  import limit_alert_pkg::*;
  logic clk_sys, rst, reg_wr, reg_rd, reg_rvalid, conv_done, ext_drv;
  logic pin_i, pin_o, pin_oe, osc_enable, internal_tick;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, bus_reading, power_value;
  logic signed [15:0] shunt_reading, current_value;
  int miscompares = 0;
  int n_checks = 0;
  // Open-drain pin with pull-up; the DUT pull-down overrides the external clock
  assign pin_i = pin_oe ? 1'b0 : ext_drv;
  reg_host_model i_reg_host_model (.clk_sys(clk_sys), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  limit_alert_and_timebase_ctrl #(.DIV_WIDTH(DIV_W))
    i_limit_alert_and_timebase_ctrl (.clk_sys(clk_sys), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .conv_done(conv_done), .shunt_reading(shunt_reading),
    .bus_reading(bus_reading), .current_value(current_value),
    .power_value(power_value), .timebase_or_alert_pin_i(pin_i),
    .timebase_or_alert_pin_o(pin_o), .timebase_or_alert_pin_oe(pin_oe),
    .osc_enable(osc_enable), .internal_tick(internal_tick));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    i_reg_host_model.rd(a, d, v);
    chk({nm, " valid"}, {15'h0, v}, 16'h0001);
    chk(nm, d, exp);
  endtask
  task automatic conv(input logic signed [15:0] s, input logic [13:0] b);
    @(negedge clk_sys);
    conv_done = 1'b1;
    shunt_reading = s;
    bus_reading = {b, 2'b11};
    @(negedge clk_sys);
    conv_done = 1'b0;
  endtask
  task automatic pin_chk(input logic exp);
    repeat (3) @(negedge clk_sys);
    chk("pin pull-down", {15'h0, pin_oe}, {15'h0, exp});
    chk("pin level", {15'h0, pin_o}, 16'h0000);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rc("shunt limits", ADDR_SHUNT_LIM, RST_SHUNT_LIM);
    rc("bus limits", ADDR_BUS_LIM, RST_BUS_LIM);
    rc("flags", ADDR_WARN, 16'h0000);
    rc("control", ADDR_CTRL, RST_CTRL);
    rc("unmapped", 8'h0a, 16'h0000);
    chk("oscillator", {15'h0, osc_enable}, 16'h0001);
    $display("test reset done");
  endtask
  task automatic t_limits();
    // Upper +1 and lower -1 count on shunt, 2 and 1 counts on bus
    i_reg_host_model.wr(ADDR_SHUNT_LIM, 16'h01ff);
    i_reg_host_model.wr(ADDR_BUS_LIM, 16'h0201);
    rc("shunt limits", ADDR_SHUNT_LIM, 16'h01ff);
    conv(16'sd256, 14'd128);
    rc("flags at limits", ADDR_WARN, 16'h0000);
    conv(16'sd257, 14'd128);
    rc("shunt over", ADDR_WARN, 16'h0008);
    conv(-16'sd256, 14'd64);
    rc("low boundaries", ADDR_WARN, 16'h0008);
    conv(-16'sd257, 14'd129);
    rc("shunt under bus over", ADDR_WARN, 16'h000e);
    conv(16'sd0, 14'd63);
    rc("bus under", ADDR_WARN, 16'h000f);
    i_reg_host_model.wr(ADDR_WARN, 16'h0000);
    rc("zero write", ADDR_WARN, 16'h000f);
    i_reg_host_model.wr(ADDR_WARN, 16'h0005);
    rc("partial clear", ADDR_WARN, 16'h000a);
    i_reg_host_model.wr(ADDR_WARN, 16'h000f);
    rc("full clear", ADDR_WARN, 16'h0000);
    // Trip and clear of one flag in one cycle: the trip must win
    fork
      i_reg_host_model.wr(ADDR_WARN, 16'h0001);
      conv(16'sd0, 14'd63);
    join
    rc("set over clear", ADDR_WARN, 16'h0001);
    i_reg_host_model.wr(ADDR_WARN, 16'h0001);
    rc("cleared again", ADDR_WARN, 16'h0000);
    $display("test limits done");
  endtask
  task automatic t_alert();
    shunt_reading = 16'sd300;
    repeat (4) @(negedge clk_sys);
    rc("no conversion", ADDR_WARN, 16'h0000);
    conv(16'sd300, 14'd100);
    pin_chk(1'b0);
    i_reg_host_model.wr(ADDR_CTRL, 16'h0080);
    pin_chk(1'b1);
    i_reg_host_model.wr(ADDR_WARN, 16'h0008);
    pin_chk(1'b0);
    i_reg_host_model.wr(ADDR_CTRL, 16'h0100);
    pin_chk(1'b1);
    i_reg_host_model.wr(ADDR_CTRL, 16'h0000);
    pin_chk(1'b0);
    $display("test alert done");
  endtask
  task automatic t_results();
    current_value = 16'sh8001;
    power_value = 16'hfffe;
    conv(16'sd0, 14'd100);
    rc("current", ADDR_CURRENT, 16'h8001);
    i_reg_host_model.wr(ADDR_POWER, 16'h0000);
    rc("power", ADDR_POWER, 16'hfffe);
    $display("test results done");
  endtask
  task automatic t_timebase();
    int toggles;
    logic prev;
    toggles = 0;
    i_reg_host_model.wr(ADDR_CTRL, 16'h0041);
    rc("control", ADDR_CTRL, 16'h0041);
    chk("oscillator", {15'h0, osc_enable}, 16'h0000);
    prev = internal_tick;
    for (int i = 0; i < 18; i++) begin
      ext_drv = i[0];
      repeat (10) begin
        @(negedge clk_sys);
        if (internal_tick !== prev) begin
          toggles++;
        end
        prev = internal_tick;
      end
    end
    // Nine rising edges at divider 1 give four toggles
    chk("tick toggles", 16'(toggles), 16'h0004);
    i_reg_host_model.wr(ADDR_CTRL, 16'h0000);
    $display("test timebase done");
  endtask
  initial begin
    rst = 1'b1;
    conv_done = 1'b0;
    ext_drv = 1'b1;
    shunt_reading = 16'sd0;
    bus_reading = 16'h0000;
    current_value = 16'sd0;
    power_value = 16'h0000;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_limits();
    t_alert();
    t_results();
    t_timebase();
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    report_and_stop();
  end
endmodule // limit_alert_and_timebase_ctrl_tb
`default_nettype wire
